// *** design/twps_consts.svh ***
/*
 twps_consts.svh: offsets, reset values and timing counts for the
 two-wire paged register slave.
 assumes: included by bare name from design files and from the testbench.
*/
`ifndef TWPS_CONSTS_SVH
`define TWPS_CONSTS_SVH
// ----------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------
`define TWPS_OFF_CTRL 12'h000
`define TWPS_OFF_BASE 12'h004
`define TWPS_OFF_STAT 12'h008
// ----------------------------------------------------------------
// reset values, field positions, master code and voltage register range
// ----------------------------------------------------------------
`define TWPS_CTRL_RST 4'h3
`define TWPS_BASE_RST 8'hb0
`define TWPS_CTRL_IFEN 0
`define TWPS_CTRL_TMO 1
`define TWPS_CTRL_HSC 2
`define TWPS_CTRL_RPW 3
`define TWPS_PG_RET 7
`define TWPS_PG_SEL 1
`define TWPS_MCODE 5'h01
`define TWPS_VOUT_LO 8'h20
`define TWPS_VOUT_HI 8'h2f
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TWPS_TMO_MS 35
`define TWPS_CLK_KHZ 25000
`define TWPS_STUCK_PULSES 4'h9
`endif

// *** design/twps_pkg.sv ***
/*
 twps_pkg: types of the two-wire paged register slave.
 assumes: compiled before every other design file.
*/
package twps_pkg;
   typedef enum logic [6:0] {
      TWPS_IDLE = 7'h01,
      TWPS_ADDR = 7'h02,
      TWPS_AACK = 7'h04,
      TWPS_RX = 7'h08,
      TWPS_WACK = 7'h10,
      TWPS_TX = 7'h20,
      TWPS_MACK = 7'h40
   } twps_state_t;
endpackage

// *** design/twps_line_if.sv ***
/*
 twps_line_if: synchronised line levels and bus events.
 assumes: driven by twps_line_sync, read by twps_slave, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface twps_line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport drv(output scl, sda, scl_rise, scl_fall, start, stop);
   modport use_(input scl, sda, scl_rise, scl_fall, start, stop);
endinterface
`default_nettype wire

// *** design/twps_line_sync.sv ***
/*
 twps_line_sync: two-flop synchronisers on scl and sda, edge and
 start/stop detection.
 assumes: pins asynchronous to core_clk; scl slow against core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module twps_line_sync (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // pins
   input wire logic scl_i,
   input wire logic sda_i,
   // events
   twps_line_if.drv ln
);
   logic [2:0] scl_q, scl_d;
   logic [2:0] sda_q, sda_d;

   always_comb begin
      scl_d = {scl_q[1:0], scl_i};
      sda_d = {sda_q[1:0], sda_i};
   end

   // idle bus reads high, so no false start out of reset
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= scl_d;
         sda_q <= sda_d;
      end
   end

   // stage 0 is read only by stage 1
   assign ln.scl = scl_q[1];
   assign ln.sda = sda_q[1];
   assign ln.scl_rise = scl_q[1] & ~scl_q[2];
   assign ln.scl_fall = ~scl_q[1] & scl_q[2];
   assign ln.start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   assign ln.stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

   a_start_cond: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      ln.start |-> $past(ln.sda) && !ln.sda && ln.scl)
      else $error("start flagged without sda fall under scl high");
endmodule
`default_nettype wire

// *** design/twps_slave.sv ***
/*
 twps_slave: two-wire slave giving a host access to two pages of
 byte registers, with apb control and status.
 assumes: open-drain sda resolved outside; active_mode comes from
 logic on core_clk; scl much slower than core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twps_consts.svh"
module twps_slave #(
   parameter int NREG = 64,
   parameter int TMO_CYC = `TWPS_TMO_MS * `TWPS_CLK_KHZ
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // two-wire pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // power mode
   input wire logic active_mode,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // status
   output logic hs_mode
);
   import twps_pkg::*;

   if (NREG < 2 || NREG > 256 || TMO_CYC < 2 || TMO_CYC >= 2**20) begin
      $error("twps_slave: parameter out of range");
   end
   // ----------------------------------------------------------------
   // line synchroniser
   // ----------------------------------------------------------------
   twps_line_if ln();
   twps_line_sync u_sync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .ln(ln)
   );
   // ----------------------------------------------------------------
   // apb control and status
   // ----------------------------------------------------------------
   logic [3:0] ctrl_q, ctrl_d;
   logic [7:0] slave_base_address_field;
   logic [7:0] base_d;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d;
   logic apb_acc;
   logic bus_idle_timeout_enable, continuous_high_speed_select;
   logic if_en, rpw_en;
   twps_state_t st_q, st_d;
   logic page_q, auto_return_page_zero;
   assign if_en = ctrl_q[`TWPS_CTRL_IFEN];
   assign bus_idle_timeout_enable = ctrl_q[`TWPS_CTRL_TMO];
   assign continuous_high_speed_select = ctrl_q[`TWPS_CTRL_HSC];
   assign rpw_en = ctrl_q[`TWPS_CTRL_RPW];
   assign apb_acc = psel & penable & ~pready;
   always_comb begin
      ctrl_d = ctrl_q;
      base_d = slave_base_address_field;
      prdata_d = prdata;
      pready_d = apb_acc;
      pslverr_d = 1'b0;
      if (apb_acc) begin
         prdata_d = 32'h0;
         case (paddr)
            `TWPS_OFF_CTRL: begin
               prdata_d[3:0] = ctrl_q;
               if (pwrite)
                  ctrl_d = pwdata[3:0];
            end
            `TWPS_OFF_BASE: begin
               prdata_d[7:0] = slave_base_address_field;
               if (pwrite)
                  base_d = pwdata[7:0];
            end
            `TWPS_OFF_STAT: begin
               prdata_d[3:0] = {auto_return_page_zero, st_q != TWPS_IDLE,
                  hs_mode, page_q};
            end
            default: begin
               pslverr_d = 1'b1;
            end
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= `TWPS_CTRL_RST;
         slave_base_address_field <= `TWPS_BASE_RST;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         slave_base_address_field <= base_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
      end
   end
   // ----------------------------------------------------------------
   // register pages
   // ----------------------------------------------------------------
   // no reset on the array: software owns its contents
   logic [7:0] mem [0:511];
   logic [7:0] ptr_q, ptr_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] rdval;
   logic we;
   logic vout_hit;
   assign vout_hit = ptr_q >= `TWPS_VOUT_LO && ptr_q <= `TWPS_VOUT_HI;
   always_comb begin
      if (ptr_q == 8'h00)
         rdval = {auto_return_page_zero, 5'h00, page_q, 1'b0};
      else if (32'(ptr_q) < NREG)
         rdval = mem[{page_q, ptr_q}];
      else
         rdval = 8'h00;
   end
   always_ff @(posedge core_clk) begin
      if (we)
         mem[{page_q, ptr_q}] <= sh_q;
   end
   // ----------------------------------------------------------------
   // protocol engine
   // ----------------------------------------------------------------
   logic [3:0] bit_q, bit_d;
   logic [3:0] stk_q, stk_d;
   logic [19:0] tmo_q, tmo_d;
   logic page_d, ret_d, rw_q, rw_d, first_q, first_d, hs_q, hs_d;
   logic oe_d, hs_mode_d;
   logic legal_start;
   // a restart's own scl rise has already counted one bit
   assign legal_start = st_q == TWPS_IDLE ||
      (st_q == TWPS_RX && bit_q <= 4'h1);
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      page_d = page_q;
      ret_d = auto_return_page_zero;
      rw_d = rw_q;
      first_d = first_q;
      hs_d = hs_q;
      oe_d = sda_oe;
      we = 1'b0;
      tmo_d = tmo_q;
      stk_d = stk_q;
      if (ln.scl_rise || ln.scl_fall || st_q == TWPS_IDLE)
         tmo_d = 20'h0;
      else if (bus_idle_timeout_enable)
         tmo_d = tmo_q + 20'h1;
      if (ln.scl_rise)
         stk_d = (sda_oe && !ln.sda) ? stk_q + 4'h1 : 4'h0;
      case (st_q)
         TWPS_ADDR: begin
            if (ln.scl_rise) begin
               sh_d = {sh_q[6:0], ln.sda};
               bit_d = bit_q + 4'h1;
            end else if (ln.scl_fall && bit_q == 4'h8) begin
               bit_d = 4'h0;
               if (sh_q[7:2] == slave_base_address_field[7:2]) begin
                  oe_d = 1'b1;
                  rw_d = sh_q[0];
                  page_d = sh_q[1];
                  st_d = TWPS_AACK;
               end else begin
                  // master code goes unanswered, restart follows
                  if (sh_q[7:3] == `TWPS_MCODE)
                     hs_d = 1'b1;
                  st_d = TWPS_IDLE;
               end
            end
         end
         TWPS_AACK, TWPS_WACK: begin
            if (ln.scl_fall) begin
               bit_d = 4'h0;
               if (rw_q && st_q == TWPS_AACK) begin
                  sh_d = rdval;
                  oe_d = ~rdval[7];
                  st_d = TWPS_TX;
               end else begin
                  oe_d = 1'b0;
                  if (st_q == TWPS_AACK)
                     first_d = 1'b1;
                  st_d = TWPS_RX;
               end
            end
         end
         TWPS_RX: begin
            if (ln.scl_rise) begin
               sh_d = {sh_q[6:0], ln.sda};
               bit_d = bit_q + 4'h1;
            end else if (ln.scl_fall && bit_q == 4'h8) begin
               oe_d = 1'b1;
               st_d = TWPS_WACK;
               if (first_q) begin
                  ptr_d = sh_q;
                  first_d = 1'b0;
               end else begin
                  if (ptr_q == 8'h00) begin
                     page_d = sh_q[`TWPS_PG_SEL];
                     ret_d = sh_q[`TWPS_PG_RET];
                  end else if (32'(ptr_q) < NREG &&
                     !(vout_hit && !active_mode))
                     we = 1'b1;
                  if (rpw_en)
                     first_d = 1'b1;
                  else
                     ptr_d = ptr_q + 8'h1;
               end
            end
         end
         TWPS_TX: begin
            if (ln.scl_fall) begin
               bit_d = bit_q + 4'h1;
               if (bit_q == 4'h7) begin
                  oe_d = 1'b0;
                  st_d = TWPS_MACK;
               end else begin
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_d = ~sh_q[6];
               end
            end
         end
         TWPS_MACK: begin
            if (ln.scl_rise) begin
               if (!ln.sda) begin
                  ptr_d = ptr_q + 8'h1;
                  rw_d = 1'b1;
                  st_d = TWPS_AACK;
               end else begin
                  st_d = TWPS_IDLE;
               end
            end
         end
         default: begin
            st_d = TWPS_IDLE;
         end
      endcase
      if (ln.stop) begin
         st_d = TWPS_IDLE;
         oe_d = 1'b0;
         hs_d = 1'b0;
         if (auto_return_page_zero)
            page_d = 1'b0;
      end else if (ln.start) begin
         oe_d = 1'b0;
         bit_d = 4'h0;
         st_d = legal_start ? TWPS_ADDR : TWPS_IDLE;
      end
      if (tmo_q == 20'(TMO_CYC - 1) || !if_en) begin
         st_d = TWPS_IDLE;
         oe_d = 1'b0;
      end
      if (stk_q >= `TWPS_STUCK_PULSES) begin
         st_d = TWPS_IDLE;
         oe_d = 1'b0;
         stk_d = 4'h0;
      end
      if (st_d == TWPS_IDLE)
         oe_d = 1'b0;
      hs_mode_d = hs_d | continuous_high_speed_select;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= TWPS_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         page_q <= 1'b0;
         auto_return_page_zero <= 1'b0;
         rw_q <= 1'b0;
         first_q <= 1'b0;
         hs_q <= 1'b0;
         sda_oe <= 1'b0;
         sda_o <= 1'b0;
         hs_mode <= 1'b0;
         tmo_q <= 20'h0;
         stk_q <= 4'h0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         page_q <= page_d;
         auto_return_page_zero <= ret_d;
         rw_q <= rw_d;
         first_q <= first_d;
         hs_q <= hs_d;
         sda_oe <= oe_d;
         sda_o <= 1'b0;
         hs_mode <= hs_mode_d;
         tmo_q <= tmo_d;
         stk_q <= stk_d;
      end
   end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_stop_ret;
      ln.stop && auto_return_page_zero;
   endsequence
   a_stop_idle: assert property (ln.stop |=>
      st_q == TWPS_IDLE && !sda_oe)
      else $error("stop did not return to idle");
   a_page_ret: assert property (s_stop_ret |=> !page_q)
      else $error("page not returned to zero");
   a_tmo_idle: assert property (tmo_q == 20'(TMO_CYC - 1) |=>
      st_q == TWPS_IDLE)
      else $error("bus timeout ignored");
   a_stuck_rel: assert property (stk_q >= 4'h9 |=> !sda_oe)
      else $error("stuck sda not released");
   a_hs_cont: assert property (continuous_high_speed_select |=> hs_mode)
      else $error("continuous high speed not shown");
   a_idle_quiet: assert property (st_q == TWPS_IDLE |-> !sda_oe)
      else $error("sda driven while idle");
   a_ack_drive: assert property (st_q == TWPS_ADDR &&
      $past(st_q) == TWPS_ADDR ##1 st_q == TWPS_AACK |-> sda_oe)
      else $error("address match not acknowledged");
   a_vout_lock: assert property (we |-> !(vout_hit && !active_mode))
      else $error("voltage write outside active mode");
   a_zero_read: assert property ($rose(st_q == TWPS_TX) &&
      32'(ptr_q) >= NREG |-> sh_q == 8'h00)
      else $error("missing register read nonzero");
   a_apb_ready: assert property (apb_acc |=> pready ##1 !pready)
      else $error("apb answer not single cycle");
endmodule
`default_nettype wire

// *** verif/twps_host.sv ***
/*
 twps_host: two-wire bus master that drives scl and sda.
 assumes: the bench resolves sda with a pull-up; core_clk paces bits.
*/
`timescale 1ns/1ps
`default_nettype none
module twps_host (
   // clock
   input wire logic core_clk,
   // bus
   input wire logic sda_line,
   output logic scl,
   output logic sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // 4 cycles low, 4 high: 320 ns a bit, the fastest legal pace
   task automatic bit_io(input logic b, output logic got);
      tick(2);
      sda_drv <= b;
      tick(2);
      scl <= 1'b1;
      tick(4);
      got = sda_line;
      scl <= 1'b0;
   endtask
   // also serves as the repeated start
   task automatic start();
      tick(2);
      sda_drv <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_drv <= 1'b0;
      tick(4);
      scl <= 1'b0;
   endtask
   task automatic stop();
      tick(2);
      sda_drv <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_drv <= 1'b1;
      tick(4);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], g);
      end
      bit_io(1'b1, ack);
   endtask
   task automatic rbyte(output logic [7:0] d, input logic last);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, g);
   endtask
endmodule
`default_nettype wire

// *** verif/twps_slave_tb.sv ***
/*
 twps_slave_tb: apb and two-wire tests of twps_slave.
 assumes: twps_host drives the bus; the sda pull-up is modelled here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twps_consts.svh"
module twps_slave_tb;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic active_mode = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, hs_mode, sda_o, sda_oe, scl, sda_drv, sda_line;
   logic [7:0] d;
   logic err, a;
   int mismatches = 0;
   int check_count = 0;
   always #20 core_clk = ~core_clk;
   // device only ever pulls low
   assign sda_line = sda_drv & ~(sda_oe & ~sda_o);
   twps_slave #(.NREG(64), .TMO_CYC(2000)) twps_slave_inst (
      .core_clk(core_clk), .arst_n(arst_n), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
      .active_mode(active_mode), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hs_mode(hs_mode));
   twps_host twps_host_inst (.core_clk(core_clk), .sda_line(sda_line),
      .scl(scl), .sda_drv(sda_drv));
   // ------------
   // tasks
   // ------------
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk_data(input logic [31:0] got, input logic [31:0] ex);
      check_count++;
      if (got !== ex) begin
         mismatches++;
         $display("mismatch at %0t: data %h not %h", $time, got, ex);
      end
   endtask
   task automatic chk_flag(input logic got, input logic ex);
      check_count++;
      if (got !== ex) begin
         mismatches++;
         $display("mismatch at %0t: flag %b not %b", $time, got, ex);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] wd);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40) begin
         mismatches++;
         $display("mismatch at %0t: apb timeout", $time);
         results();
      end
   endtask
   task automatic send(input logic [7:0] b, input logic ex_nack);
      twps_host_inst.wbyte(b, a);
      chk_flag(a, ex_nack);
   endtask
   task automatic head(input logic [7:0] sa, rg);
      twps_host_inst.start();
      send(sa, 1'b0);
      send(rg, 1'b0);
   endtask
   task automatic rnext(input logic last, input logic [7:0] ex);
      twps_host_inst.rbyte(d, last);
      chk_data({24'h0, d}, {24'h0, ex});
   endtask
   task automatic i2c_wr(input logic [7:0] sa, rg, dt);
      head(sa, rg);
      send(dt, 1'b0);
      twps_host_inst.stop();
   endtask
   task automatic i2c_rd(input logic [7:0] sa, rg, ex);
      head(sa, rg);
      twps_host_inst.start();
      send(sa | 8'h01, 1'b0);
      rnext(1'b1, ex);
      twps_host_inst.stop();
   endtask
   initial begin
      repeat (100000) @(posedge core_clk);
      mismatches++;
      $display("mismatch at %0t: run timeout", $time);
      results();
   end
   // ------------
   // sequence
   // ------------
   initial begin
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      apb(1'b0, `TWPS_OFF_CTRL, 32'h0);
      chk_data(rd, {28'h0, `TWPS_CTRL_RST});
      apb(1'b0, `TWPS_OFF_BASE, 32'h0);
      chk_data(rd, 32'h0000_00b0);
      apb(1'b0, 12'h00c, 32'h0);
      chk_flag(err, 1'b1);
      chk_data(rd, 32'h0);
      head(8'hb0, 8'h05);
      send(8'h12, 1'b0);
      send(8'h34, 1'b0);
      twps_host_inst.stop();
      head(8'hb0, 8'h05);
      twps_host_inst.start();
      send(8'hb1, 1'b0);
      rnext(1'b0, 8'h12);
      rnext(1'b1, 8'h34);
      twps_host_inst.stop();
      head(8'hb0, 8'h06);
      twps_host_inst.stop();
      twps_host_inst.start();
      send(8'hb1, 1'b0);
      rnext(1'b1, 8'h34);
      twps_host_inst.stop();
      i2c_rd(8'hb0, 8'h40, 8'h00);
      i2c_wr(8'hb2, 8'h05, 8'h56);
      i2c_rd(8'hb2, 8'h05, 8'h56);
      i2c_rd(8'hb0, 8'h05, 8'h12);
      i2c_wr(8'hb0, 8'h00, 8'h03);
      apb(1'b0, `TWPS_OFF_STAT, 32'h0);
      chk_flag(rd[0], 1'b1);
      i2c_rd(8'hb2, 8'h00, 8'h02);
      i2c_wr(8'hb2, 8'h00, 8'h82);
      apb(1'b0, `TWPS_OFF_STAT, 32'h0);
      chk_flag(rd[0], 1'b0);
      chk_flag(rd[3], 1'b1);
      i2c_wr(8'hb0, 8'h00, 8'h00);
      apb(1'b1, `TWPS_OFF_CTRL, 32'h0000_000b);
      head(8'hb0, 8'h07);
      send(8'haa, 1'b0);
      send(8'h03, 1'b0);
      send(8'hbb, 1'b0);
      twps_host_inst.stop();
      apb(1'b1, `TWPS_OFF_CTRL, 32'h0000_0003);
      i2c_rd(8'hb0, 8'h07, 8'haa);
      i2c_rd(8'hb0, 8'h03, 8'hbb);
      i2c_wr(8'hb0, 8'h2f, 8'h44);
      active_mode <= 1'b0;
      i2c_wr(8'hb0, 8'h2f, 8'h11);
      active_mode <= 1'b1;
      i2c_rd(8'hb0, 8'h2f, 8'h44);
      head(8'hb0, 8'h05);
      twps_host_inst.bit_io(1'b0, a);
      twps_host_inst.bit_io(1'b1, a);
      twps_host_inst.stop();
      i2c_rd(8'hb0, 8'h05, 8'h12);
      for (int k = 0; k < 8; k++) begin
         twps_host_inst.start();
         send(8'h08 | 8'(k), 1'b1);
         chk_flag(hs_mode, 1'b1);
         twps_host_inst.stop();
         twps_host_inst.tick(4);
         chk_flag(hs_mode, 1'b0);
      end
      apb(1'b1, `TWPS_OFF_CTRL, 32'h0000_0007);
      apb(1'b0, `TWPS_OFF_STAT, 32'h0);
      chk_flag(hs_mode, 1'b1);
      chk_flag(rd[1], 1'b1);
      i2c_rd(8'hb0, 8'h05, 8'h12);
      apb(1'b1, `TWPS_OFF_CTRL, 32'h0000_0002);
      twps_host_inst.start();
      send(8'hb0, 1'b1);
      twps_host_inst.stop();
      apb(1'b1, `TWPS_OFF_CTRL, 32'h0000_0003);
      twps_host_inst.start();
      send(8'hb4, 1'b1);
      twps_host_inst.stop();
      apb(1'b1, `TWPS_OFF_BASE, 32'h0000_00c0);
      i2c_rd(8'hc0, 8'h05, 8'h12);
      apb(1'b1, `TWPS_OFF_BASE, 32'h0000_00b0);
      twps_host_inst.start();
      send(8'hb0, 1'b0);
      twps_host_inst.tick(1800);
      apb(1'b0, `TWPS_OFF_STAT, 32'h0);
      chk_flag(rd[2], 1'b1);
      twps_host_inst.tick(300);
      apb(1'b0, `TWPS_OFF_STAT, 32'h0);
      chk_flag(rd[2], 1'b0);
      twps_host_inst.stop();
      i2c_rd(8'hb0, 8'h05, 8'h12);
      results();
   end
endmodule
`default_nettype wire
